/* File: rtl/rcbp_top.sv */
// Registered 28-bit command buffer with 1:2 fan-out and parity checking
`timescale 1ns/100ps
module rcbp_top
  import rcbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_config_select,
  input wire logic i_chip_select_gate_enable,
  input wire logic i_chip_select_in_0_n,
  input wire logic i_chip_select_in_1_n,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_parity_in,
  output rcbp_out_t o_out,
  output logic o_low_power_mode,
  output logic o_parity_error_n,
  output logic o_parity_error_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rst_meta_r;
  logic rst_ok_r;
  logic clear;
  logic clear_d_r;
  logic cfg_meta_r;
  logic cfg_r;
  logic cs_any;
  logic cap_en;
  logic [DATA_W-1:0] free;
  logic [DATA_W-1:0] data_nxt;
  rcbp_out_t out_nxt;
  logic lpm_nxt;
  logic par_r;
  logic par_nxt;
  logic chk_r;
  logic chk_nxt;
  logic mismatch_r;
  logic mismatch_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and config strap synchronisers
  // Assertion is immediate; release waits two edges to avoid a runt cycle
  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      rst_meta_r <= 1'h0;
      rst_ok_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_ok_r <= rst_meta_r;
    end
  end

  assign clear = i_reset || !rst_ok_r;

  // Checks wait one more edge: outputs still show the cleared state then
  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      clear_d_r <= 1'h1;
    end else begin
      clear_d_r <= clear;
    end
  end

  // Static strap, so a two-stage sync is enough
  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      cfg_meta_r <= CFG_RST;
      cfg_r <= CFG_RST;
    end else begin
      cfg_meta_r <= i_config_select;
      cfg_r <= cfg_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture and gating
  always_comb begin
    cs_any = !i_chip_select_in_0_n || !i_chip_select_in_1_n;
    cap_en = !i_chip_select_gate_enable || cs_any;
    lpm_nxt = !cap_en;
    free = rcbp_free_mask(cfg_r);
    // Free bits always follow; the rest hold when capture is blocked
    data_nxt = (i_data & free) | ((cap_en ? i_data : o_out.q_a) & ~free);
    out_nxt.q_a = data_nxt;
    out_nxt.q_b = data_nxt;
    out_nxt.cs_a = {i_chip_select_in_1_n, i_chip_select_in_0_n};
    out_nxt.cs_b = {i_chip_select_in_1_n, i_chip_select_in_0_n};
  end

  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      o_out <= OUT_RST;
      o_low_power_mode <= 1'h0;
    end else if (clear) begin
      o_out <= OUT_RST;
      o_low_power_mode <= 1'h0;
    end else begin
      o_out <= out_nxt;
      o_low_power_mode <= lpm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parity pipeline: data sum at n, paired with parity at n+1
  always_comb begin
    par_nxt = ^i_data;
    chk_nxt = cs_any;
    mismatch_nxt = chk_r && (par_r ^ i_parity_in);
  end

  // Parity is only meaningful when the controller holds inputs low after reset
  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      par_r <= 1'h0;
      chk_r <= 1'h0;
      mismatch_r <= 1'h0;
    end else if (clear) begin
      par_r <= 1'h0;
      chk_r <= 1'h0;
      mismatch_r <= 1'h0;
    end else begin
      par_r <= par_nxt;
      chk_r <= chk_nxt;
      mismatch_r <= mismatch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flag
  rcbp_parity_chk u_parity_chk (
    .i_clk(i_clk),
    .i_reset_pin_n(i_reset_pin_n),
    .i_clear(clear),
    .i_mismatch(mismatch_r),
    .i_lpm(o_low_power_mode),
    .o_parity_error_n(o_parity_error_n),
    .o_parity_error_oe(o_parity_error_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_free_follow;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      1'h1 |=> ((o_out.q_a & $past(free)) == ($past(i_data) & $past(free)));
  endproperty
  a_free_follow: assert property (p_free_follow)
    else $error("clock-enable or termination bit not forwarded");

  property p_gate_hold;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (i_chip_select_gate_enable && i_chip_select_in_0_n && i_chip_select_in_1_n)
        |=> ((o_out.q_a & ~$past(free)) == ($past(o_out.q_a) & ~$past(free)));
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("data output changed while suspended");

  property p_ungated;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      !i_chip_select_gate_enable |=> (o_out.q_a == $past(i_data));
  endproperty
  a_ungated: assert property (p_ungated)
    else $error("data not captured with gating off");

  property p_selected;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (!i_chip_select_in_0_n || !i_chip_select_in_1_n) |=> (o_out.q_a == $past(i_data));
  endproperty
  a_selected: assert property (p_selected)
    else $error("data not captured with a select low");

  property p_cs_follow;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      1'h1 |=> (o_out.cs_a == {$past(i_chip_select_in_1_n), $past(i_chip_select_in_0_n)});
  endproperty
  a_cs_follow: assert property (p_cs_follow)
    else $error("select output not forwarded");

  property p_copies;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      (o_out.q_a == o_out.q_b) && (o_out.cs_a == o_out.cs_b);
  endproperty
  a_copies: assert property (p_copies)
    else $error("A and B copies differ");

  property p_lpm;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (i_chip_select_gate_enable && i_chip_select_in_0_n && i_chip_select_in_1_n)
        |=> o_low_power_mode;
  endproperty
  a_lpm: assert property (p_lpm)
    else $error("low-power mode not entered");

  property p_parity_timing;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      ((!$past(i_chip_select_in_0_n) || !$past(i_chip_select_in_1_n))
        && (^$past(i_data) ^ i_parity_in)) |-> ##2 !o_parity_error_n;
  endproperty
  a_parity_timing: assert property (p_parity_timing)
    else $error("parity error not flagged at n+3");

  property p_reset_outputs;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      i_reset |=> (o_parity_error_n && (o_out == OUT_RST) && !o_low_power_mode);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not cleared by reset");

  property p_clear_outputs;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      clear
        |=> ((o_out == OUT_RST) && !o_low_power_mode && o_parity_error_n);
  endproperty
  a_clear_outputs: assert property (p_clear_outputs)
    else $error("outputs not held cleared during reset release");

  property p_lpm_off;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (!i_chip_select_gate_enable || !i_chip_select_in_0_n || !i_chip_select_in_1_n)
        |=> !o_low_power_mode;
  endproperty
  a_lpm_off: assert property (p_lpm_off)
    else $error("low-power mode without its condition");

  property p_hold_b;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (i_chip_select_gate_enable && i_chip_select_in_0_n && i_chip_select_in_1_n)
        |=> ((o_out.q_b & ~$past(free)) == ($past(o_out.q_b) & ~$past(free)));
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("B copy changed while suspended");

  property p_cfg_map;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      cfg_r |-> (free[B_CKE0_POS] && free[B_CKE1_POS] && free[B_ODT0_POS]
        && free[B_ODT1_POS] && !free[A_CKE0_POS] && !free[A_ODT0_POS]);
  endproperty
  a_cfg_map: assert property (p_cfg_map)
    else $error("mapping B bits not selected");

  property p_cs_b_follow;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      1'h1
        |=> (o_out.cs_b == {$past(i_chip_select_in_1_n), $past(i_chip_select_in_0_n)});
  endproperty
  a_cs_b_follow: assert property (p_cs_b_follow)
    else $error("B select output not forwarded");

  property p_err_gen;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      mismatch_r
        |=> !o_parity_error_n;
  endproperty
  a_err_gen: assert property (p_err_gen)
    else $error("error flag not driven after a mismatch");

  property p_idle_unchecked;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      (i_chip_select_in_0_n && i_chip_select_in_1_n)
        |=> ##1 !mismatch_r;
  endproperty
  a_idle_unchecked: assert property (p_idle_unchecked)
    else $error("parity checked with no select low");

  property p_parity_ok;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      ((!$past(i_chip_select_in_0_n) || !$past(i_chip_select_in_1_n))
        && !(^$past(i_data) ^ i_parity_in)) |=> !mismatch_r;
  endproperty
  a_parity_ok: assert property (p_parity_ok)
    else $error("mismatch raised for even parity");

  property p_err_release;
    @(posedge i_clk) disable iff (clear || clear_d_r || !i_reset_pin_n)
      $rose(o_parity_error_n)
        |-> !$past(o_parity_error_n, 2);
  endproperty
  a_err_release: assert property (p_err_release)
    else $error("error flag released too early");

  property p_no_false_err;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      (o_parity_error_n && !mismatch_r)
        |=> o_parity_error_n;
  endproperty
  a_no_false_err: assert property (p_no_false_err)
    else $error("error flag raised without a mismatch");

endmodule // rcbp_top

/* File: rtl/rcbp_pkg.sv */
// Constants, types and helpers shared by the registered command buffer
package rcbp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W = 28;
  localparam int CS_W = 2;

  ////////////////////////////////////////////////////////////////////////
  // Positions of the never-suspended bits, data input 1 is bit 0
  // Mapping A (config select low)
  localparam int A_CKE0_POS = 7;
  localparam int A_CKE1_POS = 5;
  localparam int A_ODT0_POS = 14;
  localparam int A_ODT1_POS = 15;
  // Mapping B (config select high)
  localparam int B_CKE0_POS = 20;
  localparam int B_CKE1_POS = 22;
  localparam int B_ODT0_POS = 13;
  localparam int B_ODT1_POS = 12;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and timing counts
  localparam logic [DATA_W-1:0] DATA_RST = 28'h0000000;
  localparam logic [CS_W-1:0] CS_RST = 2'h0;
  localparam logic ERR_N_RST = 1'h1;
  localparam logic CFG_RST = 1'h0;
  localparam logic [1:0] ERR_HOLD_CYCLES = 2'h2;
  localparam logic [1:0] CNT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [DATA_W-1:0] q_a;
    logic [DATA_W-1:0] q_b;
    logic [CS_W-1:0] cs_a;
    logic [CS_W-1:0] cs_b;
  } rcbp_out_t;

  localparam rcbp_out_t OUT_RST = '{DATA_RST, DATA_RST, CS_RST, CS_RST};

  typedef enum logic [2:0] {
    ERR_CLEAR = 3'h1,
    ERR_HOLD = 3'h2,
    ERR_SLEEP = 3'h4
  } rcbp_err_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Mask of clock-enable and termination bits for a mapping
  function automatic logic [DATA_W-1:0] rcbp_free_mask(input logic cfg_b);
    logic [DATA_W-1:0] m;
    m = DATA_RST;
    if (cfg_b) begin
      m[B_CKE0_POS] = 1'h1;
      m[B_CKE1_POS] = 1'h1;
      m[B_ODT0_POS] = 1'h1;
      m[B_ODT1_POS] = 1'h1;
    end else begin
      m[A_CKE0_POS] = 1'h1;
      m[A_CKE1_POS] = 1'h1;
      m[A_ODT0_POS] = 1'h1;
      m[A_ODT1_POS] = 1'h1;
    end
    return m;
  endfunction

endpackage

/* File: rtl/rcbp_parity_chk.sv */
// Parity error flag with latched low hold and low-power extension
`timescale 1ns/100ps
module rcbp_parity_chk
  import rcbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_pin_n,
  input wire logic i_clear,
  input wire logic i_mismatch,
  input wire logic i_lpm,
  output logic o_parity_error_n,
  output logic o_parity_error_oe
);

  rcbp_err_state_t state_r;
  rcbp_err_state_t state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic err_n_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Hold sequencing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    err_n_nxt = o_parity_error_n;
    case (state_r)
      ERR_CLEAR: begin
        if (i_mismatch) begin
          state_nxt = ERR_HOLD;
          cnt_nxt = ERR_HOLD_CYCLES - 2'h1;
          err_n_nxt = 1'h0;
        end
      end
      ERR_HOLD: begin
        if (i_mismatch) begin
          cnt_nxt = ERR_HOLD_CYCLES - 2'h1;
        end else if (i_lpm) begin
          state_nxt = ERR_SLEEP;
        end else if (cnt_r == CNT_RST) begin
          state_nxt = ERR_CLEAR;
          err_n_nxt = 1'h1;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      ERR_SLEEP: begin
        // Two more cycles counted only once the sleep ends
        if (i_mismatch || !i_lpm) begin
          state_nxt = ERR_HOLD;
          cnt_nxt = ERR_HOLD_CYCLES - 2'h1;
        end
      end
      default: begin
        state_nxt = ERR_CLEAR;
        cnt_nxt = CNT_RST;
        err_n_nxt = ERR_N_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_pin_n) begin
    if (!i_reset_pin_n) begin
      state_r <= ERR_CLEAR;
      cnt_r <= CNT_RST;
      o_parity_error_n <= ERR_N_RST;
      o_parity_error_oe <= 1'h0;
    end else if (i_clear) begin
      state_r <= ERR_CLEAR;
      cnt_r <= CNT_RST;
      o_parity_error_n <= ERR_N_RST;
      o_parity_error_oe <= 1'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_parity_error_n <= err_n_nxt;
      o_parity_error_oe <= !err_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_err_hold_two;
    @(posedge i_clk) disable iff (i_clear || !i_reset_pin_n)
      $fell(o_parity_error_n) |=> !o_parity_error_n;
  endproperty
  a_err_hold_two: assert property (p_err_hold_two)
    else $error("error flag released before two cycles");

  property p_err_sleep_hold;
    @(posedge i_clk) disable iff (i_clear || !i_reset_pin_n)
      (!o_parity_error_n && i_lpm) |=> !o_parity_error_n [*2];
  endproperty
  a_err_sleep_hold: assert property (p_err_sleep_hold)
    else $error("error flag released during low-power hold");

  property p_err_oe;
    @(posedge i_clk) disable iff (!i_reset_pin_n)
      o_parity_error_oe == !o_parity_error_n;
  endproperty
  a_err_oe: assert property (p_err_oe)
    else $error("open-drain enable disagrees with flag");

endmodule // rcbp_parity_chk

/* File: verification/rcbp_ctrl_model.sv */
// Controller model driving command, select and delayed parity lines
`timescale 1ns/100ps
module rcbp_ctrl_model
  import rcbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DATA_W-1:0] i_word,
  input wire logic [CS_W-1:0] i_cs_n,
  input wire logic i_flip,
  output logic [DATA_W-1:0] o_data,
  output logic o_cs0_n,
  output logic o_cs1_n,
  output logic o_parity
);
  logic par_r = 1'h0;

  ////////////////////////////////////////////////////////////////////////
  // Bench chooses the select level for each command
  assign o_data = i_word;
  assign o_cs0_n = i_cs_n[0];
  assign o_cs1_n = i_cs_n[1];

  ////////////////////////////////////////////////////////////////////////
  // Even parity of the word just taken, corrupted only on request
  always @(posedge i_clk) begin
    par_r <= (^i_word) ^ i_flip;
  end
  initial o_parity = 1'h0;
  // Driven mid-cycle so the device sees it one edge after the data
  always @(negedge i_clk) begin
    o_parity <= par_r;
  end
endmodule // rcbp_ctrl_model

/* File: verification/rcbp_tb_top.sv */
// Self-checking bench for the registered command buffer
`timescale 1ns/100ps
module rcbp_tb_top;
  import rcbp_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic pin_n = 1'h0;
  logic cfg = 1'h0;
  logic gate = 1'h0;
  logic [DATA_W-1:0] word = DATA_RST;
  logic [CS_W-1:0] cs_n = 2'h3;
  logic flip = 1'h0;
  logic [DATA_W-1:0] d_w;
  logic cs0_w;
  logic cs1_w;
  logic par_w;
  rcbp_out_t out_w;
  logic lpm_w;
  logic err_n_w;
  logic oe_w;
  logic [DATA_W-1:0] exp_q = DATA_RST;
  int bad_count = 0;
  int n_tests = 0;
  int k;

  always #50 clk = ~clk;

  rcbp_ctrl_model i_ctrl (.i_clk(clk), .i_word(word), .i_cs_n(cs_n), .i_flip(flip),
    .o_data(d_w), .o_cs0_n(cs0_w), .o_cs1_n(cs1_w), .o_parity(par_w));

  rcbp_top i_dut (.i_clk(clk), .i_reset(rst), .i_reset_pin_n(pin_n), .i_config_select(cfg),
    .i_chip_select_gate_enable(gate), .i_chip_select_in_0_n(cs0_w),
    .i_chip_select_in_1_n(cs1_w), .i_data(d_w), .i_parity_in(par_w), .o_out(out_w),
    .o_low_power_mode(lpm_w), .o_parity_error_n(err_n_w), .o_parity_error_oe(oe_w));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Inputs change at the falling edge; outputs then show the previous capture
  task automatic tick(input logic [DATA_W-1:0] w, input logic [CS_W-1:0] c, input logic g,
    input logic f);
    @(negedge clk);
    word = w;
    cs_n = c;
    gate = g;
    flip = f;
  endtask

  function automatic logic [DATA_W-1:0] fmask(input logic b);
    fmask = b ? ((28'h1 << B_CKE0_POS) | (28'h1 << B_CKE1_POS) | (28'h1 << B_ODT0_POS)
      | (28'h1 << B_ODT1_POS)) : ((28'h1 << A_CKE0_POS) | (28'h1 << A_CKE1_POS)
      | (28'h1 << A_ODT0_POS) | (28'h1 << A_ODT1_POS));
  endfunction

  // All gate and select combinations; each word taken twice
  task automatic run_modes(input logic b);
    logic [DATA_W-1:0] w;
    logic hold;
    for (int m = 0; m < 8; m++) begin
      w = 28'h5A3C96E ^ {7{m[3:0]}} ^ {28{b}};
      hold = (m[2] == 1'h1) && (m[1:0] == 2'h3);
      exp_q = hold ? ((exp_q & ~fmask(b)) | (w & fmask(b))) : w;
      tick(w, m[1:0], m[2], 1'h0);
      tick(w, m[1:0], m[2], 1'h0);
      chk_word(out_w.q_a, exp_q);
      chk_word(out_w.q_b, exp_q);
      chk_word({26'h0, out_w.cs_a}, {26'h0, m[1:0]});
      chk_word({26'h0, out_w.cs_b}, {26'h0, m[1:0]});
      chk_bit(lpm_w, hold);
      chk_bit(err_n_w, 1'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    chk_bit(err_n_w, 1'h1);
    chk_word(out_w.q_a, DATA_RST);
    repeat (2) @(negedge clk);
    pin_n = 1'h1;
    rst = 1'h0;
    repeat (4) tick(DATA_RST, 2'h3, 1'h0, 1'h0);
    run_modes(1'h0);
    // Plain parity error: low two cycles, then released
    tick(28'h0000001, 2'h2, 1'h0, 1'h1);
    for (k = 0; k < 5; k++) begin
      tick(DATA_RST, 2'h2, 1'h0, 1'h0);
      chk_bit(err_n_w, !(k == 2 || k == 3));
      chk_bit(oe_w, (k == 2 || k == 3));
    end
    // Error just before low power stays through it
    tick(28'h0000001, 2'h2, 1'h1, 1'h1);
    for (k = 0; k < 6; k++) begin
      tick(DATA_RST, 2'h3, 1'h1, 1'h0);
      chk_bit(err_n_w, k < 2);
      chk_bit(lpm_w, k >= 1);
    end
    tick(DATA_RST, 2'h2, 1'h1, 1'h0);
    tick(DATA_RST, 2'h2, 1'h1, 1'h0);
    chk_bit(lpm_w, 1'h0);
    chk_bit(err_n_w, 1'h0);
    // Bounded wait for the release after the extension
    for (k = 0; k < 4 && err_n_w !== 1'h1; k++) begin
      tick(DATA_RST, 2'h2, 1'h1, 1'h0);
    end
    chk_bit(err_n_w, 1'h1);
    // Pin reset in mid-hold with nonzero outputs
    tick(28'h0000001, 2'h2, 1'h0, 1'h1);
    repeat (3) tick(28'hFFFFFFF, 2'h2, 1'h0, 1'h0);
    chk_bit(err_n_w, 1'h0);
    #20 pin_n = 1'h0;
    #1;
    chk_word(out_w.q_a, DATA_RST);
    chk_word(out_w.q_b, DATA_RST);
    chk_bit(err_n_w, 1'h1);
    chk_bit(oe_w, 1'h0);
    tick(DATA_RST, 2'h3, 1'h0, 1'h0);
    pin_n = 1'h1;
    exp_q = DATA_RST;
    cfg = 1'h1;
    repeat (5) tick(DATA_RST, 2'h3, 1'h0, 1'h0);
    chk_word(out_w.q_a, DATA_RST);
    run_modes(1'h1);
    // Synchronous reset while outputs and low-power are set
    rst = 1'h1;
    tick(DATA_RST, 2'h3, 1'h0, 1'h0);
    rst = 1'h0;
    chk_word(out_w.q_a, DATA_RST);
    chk_word({26'h0, out_w.cs_a}, {26'h0, CS_RST});
    chk_bit(lpm_w, 1'h0);
    tick(DATA_RST, 2'h3, 1'h0, 1'h0);
    close_out();
  end
endmodule // rcbp_tb_top
